// >>> hw/imsc_defs.svh
`ifndef IMSC_DEFS_SVH
`define IMSC_DEFS_SVH
// Slave address used until the one-time parameter is programmed
`define IMSC_SLAVE_ADDR_DFLT 7'h40
// Clock multiplication factors, in divider ticks per serial clock period
`define IMSC_M_SLOW 4'd8
`define IMSC_M_FAST 4'd6
// Requested rates below this figure (kHz) take the slow factor
`define IMSC_SLOW_KHZ 12'd100
// Divider range
`define IMSC_N_MIN 7'd1
`define IMSC_N_MAX 7'd127
// Low phase of every bit, in divider ticks
`define IMSC_LOW_TICKS 4'd4
// Start hold before the first clock fall, in divider ticks
`define IMSC_START_HOLD 4'd4
// Setup before start and before stop, in divider ticks
`define IMSC_SETUP_TICKS 4'd2
// Bus free time after a stop, in divider ticks
`define IMSC_BUS_FREE 4'd4
`endif

// >>> hw/imsc_pkg.sv
package imsc_pkg;
	// Master commands
	typedef enum logic [1:0] {
		IMSC_OP_ADDR  = 2'b00,
		IMSC_OP_WRITE = 2'b01,
		IMSC_OP_READ  = 2'b10,
		IMSC_OP_STOP  = 2'b11
	} imsc_op_t;
	// One master command: start+address, byte write, byte read or stop
	typedef struct packed {
		imsc_op_t   op;
		logic [6:0] addr; // Slave address for IMSC_OP_ADDR
		logic       rw;   // 0 write, 1 read
		logic [7:0] data; // Byte for IMSC_OP_WRITE
		logic       nack; // Leave a read byte unacknowledged
	} imsc_cmd_t;
	// Master answer after each address or data byte
	typedef struct packed {
		logic [7:0] data; // Byte received on a read
		logic       nack; // Acknowledge bit seen on the wire
	} imsc_rsp_t;
endpackage

// >>> hw/imsc_ctrl.sv
// What this block does
// R1 - Serial clock is operating clock over M times (N+1)
// R2 - M is eight below 100 kHz, else six
// R3 - Operating clock is 48, 60 or 80 MHz
// R4 - Clock open-drain as master, input as slave
// R5 - Master and slave, each transmitting and receiving
// R6 - Start, seven address bits, then direction bit
// R7 - Matching slave acknowledges low; roles then complement
// R8 - Address and data go most significant first
// R9 - Start falls, stop rises, data while clock high
// R10 - Write bytes each acknowledged by the slave
// R11 - Master acknowledges read bytes except the last
// R12 - Transfer ends with stop or repeated start
// R13 - Repeated start never preceded by a stop
// R14 - Master may send any seven-bit address
// R15 - Slave address defaults 40h, programmable once
// R16 - Start held four divider ticks before clock falls
// R17 - Slave ignores transfers to other addresses
`include "imsc_defs.svh"
module imsc_ctrl #(
	parameter int OP_CLK_MHZ = 48 // R3: 48, 60 or 80; bus timing counts in its periods
) (
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst,
	// Configuration
	input  wire logic                master_mode,
	input  wire logic [6:0]          div_n,
	input  wire logic [11:0]         target_khz,
	input  wire logic                otp_wr,
	input  wire logic [6:0]          otp_addr,
	// Master command and answer
	input  wire logic                cmd_valid,
	output logic                     cmd_ready,
	input  wire imsc_pkg::imsc_cmd_t cmd,
	output logic                     rsp_valid,
	output imsc_pkg::imsc_rsp_t      rsp,
	// Slave data
	output logic                     s_rx_valid,
	output logic [7:0]               s_rx_data,
	output logic                     s_tx_req,
	input  wire logic [7:0]          s_tx_data,
	output logic                     s_busy,
	// Bus pins
	input  wire logic                scl_in,
	output logic                     scl_oe,
	input  wire logic                sda_in,
	output logic                     sda_oe
);
	import imsc_pkg::*;

	typedef enum logic [3:0] {
		M_IDLE = 4'h0, M_SLOW = 4'h1, M_SHIGH = 4'h2, M_SHOLD = 4'h3, M_LOW = 4'h4,
		M_HIGH = 4'h5, M_PLOW = 4'h6, M_PHIGH = 4'h7, M_PFREE = 4'h8
	} imsc_mst_t;
	typedef enum logic [2:0] {
		S_IDLE = 3'h0, S_ADDR = 3'h1, S_AACK = 3'h2, S_RX = 3'h3, S_RACK = 3'h4,
		S_TX = 3'h5, S_TACK = 3'h6, S_IGN = 3'h7
	} imsc_slv_t;

	// Clock factor from the requested rate
	function automatic logic [3:0] clk_factor(input logic [11:0] khz);
		clk_factor = (khz < `IMSC_SLOW_KHZ) ? `IMSC_M_SLOW : `IMSC_M_FAST; // R2
	endfunction

	logic [6:0] div_cnt;    // Divider count
	logic       tick;       // One pulse per N+1 operating clocks
	logic [6:0] n_eff;      // Divider clamped to its legal range
	logic [3:0] hi_ticks;   // High phase length
	imsc_mst_t  m_state;    // Master sequencer
	logic [3:0] ph;         // Ticks spent in the current phase
	logic [8:0] m_sh;       // Outgoing bits, MSB first, ninth is acknowledge
	logic [7:0] m_rx;       // Incoming bits
	logic [3:0] m_bit;      // Bit index within the byte
	logic       owned;      // Bus held between transfers
	logic       m_scl_oe;   // Master clock drive
	logic       m_sda_oe;   // Master data drive
	imsc_slv_t  s_state;    // Slave sequencer
	logic       scl_q;      // Pins one cycle ago, for edge detection
	logic       sda_q;
	logic [6:0] slave_addr; // Address the slave answers to
	logic       otp_done;   // Programming already used
	logic [7:0] s_sh;       // Slave shift register
	logic [2:0] s_cnt;      // Slave bit count
	logic       s_sda_oe;   // Slave data drive
	logic       s_got8;     // Eight bits shifted in, acknowledge slot comes next
	logic       bus_start;  // Start seen on the wire
	logic       bus_stop;   // Stop seen on the wire
	logic       scl_rise;
	logic       scl_fall;

	assign n_eff    = (div_n < `IMSC_N_MIN) ? `IMSC_N_MIN : div_n;
	assign hi_ticks = clk_factor(target_khz) - `IMSC_LOW_TICKS; // R1 R2
	assign tick     = (div_cnt == n_eff);

	// Divider: one tick every N+1 operating clocks
	always_ff @(posedge ref_clk) begin
		if (rst || tick || m_state == M_IDLE) begin
			div_cnt <= 7'h00;
		end else begin
			div_cnt <= div_cnt + 7'h01; // R1
		end
	end

	assign cmd_ready = master_mode && (m_state == M_IDLE);

	// Master sequencer: start, bits, stop, all paced by the divider
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			m_state   <= M_IDLE;
			ph        <= 4'h0;
			m_sh      <= 9'h1ff;
			m_rx      <= 8'h00;
			m_bit     <= 4'h0;
			owned     <= 1'b0;
			m_scl_oe  <= 1'b0;
			m_sda_oe  <= 1'b0;
			rsp_valid <= 1'b0;
			rsp       <= '0;
		end else begin
			rsp_valid <= 1'b0;
			case (m_state)
				M_IDLE: begin
					ph <= 4'h0;
					if (cmd_valid && cmd_ready) begin
						m_bit <= 4'h0;
						case (cmd.op)
							IMSC_OP_ADDR: begin
								m_sh    <= {cmd.addr, cmd.rw, 1'b1}; // R6 R8 R14
								m_state <= M_SLOW; // R12 R13: no stop before restart
							end
							IMSC_OP_WRITE: begin
								m_sh    <= {cmd.data, 1'b1}; // R8 R10
								m_state <= M_LOW;
							end
							IMSC_OP_READ: begin
								m_sh    <= {8'hff, cmd.nack}; // R11
								m_state <= M_LOW;
							end
							default: m_state <= M_PLOW; // R12
						endcase
					end
				end
				// Release data during the low phase, so a restart can follow a byte
				M_SLOW: if (tick) begin
					m_sda_oe <= 1'b0;
					ph       <= ph + 4'h1;
					if (!owned || ph == `IMSC_LOW_TICKS - 4'h1) begin
						ph       <= 4'h0;
						m_scl_oe <= 1'b0;
						m_state  <= M_SHIGH;
					end
				end
				M_SHIGH: if (tick) begin
					ph <= ph + 4'h1;
					if (ph == `IMSC_SETUP_TICKS - 4'h1) begin
						ph       <= 4'h0;
						m_sda_oe <= 1'b1; // R9: data falls with clock high
						owned    <= 1'b1;
						m_state  <= M_SHOLD;
					end
				end
				M_SHOLD: if (tick) begin
					ph <= ph + 4'h1;
					if (ph == `IMSC_START_HOLD - 4'h1) begin
						ph       <= 4'h0;
						m_scl_oe <= 1'b1; // R16
						m_state  <= M_LOW;
					end
				end
				M_LOW: if (tick) begin
					m_scl_oe <= 1'b1; // R4
					ph       <= ph + 4'h1;
					if (ph == 4'h0) begin
						m_sda_oe <= ~m_sh[8]; // R8
					end
					if (ph == `IMSC_LOW_TICKS - 4'h1) begin
						ph       <= 4'h0;
						m_scl_oe <= 1'b0;
						m_state  <= M_HIGH;
					end
				end
				M_HIGH: if (tick) begin
					ph <= ph + 4'h1;
					if (ph == hi_ticks - 4'h1) begin
						ph       <= 4'h0;
						m_scl_oe <= 1'b1;
						m_sh     <= {m_sh[7:0], 1'b1};
						m_bit    <= m_bit + 4'h1;
						if (m_bit == 4'h8) begin
							rsp_valid <= 1'b1;
							rsp       <= '{data: m_rx, nack: sda_in}; // R7 R10
							m_state   <= M_IDLE;
						end else begin
							m_rx    <= {m_rx[6:0], sda_in}; // R8
							m_state <= M_LOW;
						end
					end
				end
				M_PLOW: if (tick) begin
					m_scl_oe <= 1'b1;
					m_sda_oe <= 1'b1;
					ph       <= ph + 4'h1;
					if (ph == `IMSC_LOW_TICKS - 4'h1) begin
						ph       <= 4'h0;
						m_scl_oe <= 1'b0;
						m_state  <= M_PHIGH;
					end
				end
				M_PHIGH: if (tick) begin
					ph <= ph + 4'h1;
					if (ph == `IMSC_SETUP_TICKS - 4'h1) begin
						ph       <= 4'h0;
						m_sda_oe <= 1'b0; // R9: data rises with clock high
						owned    <= 1'b0;
						m_state  <= M_PFREE;
					end
				end
				M_PFREE: if (tick) begin
					ph <= ph + 4'h1;
					if (ph == `IMSC_BUS_FREE - 4'h1) begin
						m_state <= M_IDLE;
					end
				end
				default: m_state <= M_IDLE;
			endcase
		end
	end

	// Slave address: defaults at reset, takes one programming only
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			slave_addr <= `IMSC_SLAVE_ADDR_DFLT;
			otp_done   <= 1'b0;
		end else if (otp_wr && !otp_done) begin
			slave_addr <= otp_addr; // R15
			otp_done   <= 1'b1;
		end
	end

	// Pin history for the slave edge detectors
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_in;
			sda_q <= sda_in;
		end
	end

	assign bus_start = scl_in && scl_q && sda_q && !sda_in; // R9
	assign bus_stop  = scl_in && scl_q && !sda_q && sda_in; // R9
	assign scl_rise  = scl_in && !scl_q;
	assign scl_fall  = !scl_in && scl_q;
	assign s_busy    = (s_state != S_IDLE);

	// Slave sequencer; the slave only watches the clock, never drives it
	always_ff @(posedge ref_clk) begin
		if (rst || master_mode) begin
			s_state    <= S_IDLE;
			s_sh       <= 8'h00;
			s_cnt      <= 3'h0;
			s_sda_oe   <= 1'b0;
			s_rx_valid <= 1'b0;
			s_rx_data  <= 8'h00;
			s_tx_req   <= 1'b0;
			s_got8     <= 1'b0;
		end else begin
			s_rx_valid <= 1'b0;
			s_tx_req   <= 1'b0;
			if (bus_start) begin
				s_state  <= S_ADDR; // R13: a restart also lands here
				s_cnt    <= 3'h0;
				s_got8   <= 1'b0;
				s_sda_oe <= 1'b0;
			end else if (bus_stop) begin
				s_state  <= S_IDLE;
				s_got8   <= 1'b0;
				s_sda_oe <= 1'b0;
			end else begin
				case (s_state)
					S_ADDR, S_RX: begin
						if (scl_rise) begin
							s_sh   <= {s_sh[6:0], sda_in}; // R8
							s_cnt  <= s_cnt + 3'h1;
							s_got8 <= (s_cnt == 3'h7);
						end
						// The clock fall that closes a start must not count as a byte end
						if (scl_fall && s_got8) begin
							s_got8 <= 1'b0;
							if (s_state == S_RX) begin
								s_rx_valid <= 1'b1;
								s_rx_data  <= s_sh;
								s_sda_oe   <= 1'b1; // R10
								s_state    <= S_RACK;
							end else if (s_sh[7:1] == slave_addr) begin
								s_sda_oe <= 1'b1; // R7
								s_state  <= S_AACK;
							end else begin
								s_state <= S_IGN; // R17
							end
						end
					end
					S_AACK, S_RACK: if (scl_fall) begin
						s_sda_oe <= 1'b0;
						if (s_state == S_AACK && s_sh[0]) begin
							s_sh     <= s_tx_data; // R5 R7: slave transmits
							s_sda_oe <= ~s_tx_data[7];
							s_tx_req <= 1'b1;
							s_state  <= S_TX;
						end else begin
							s_state <= S_RX; // R5: slave receives
						end
					end
					S_TX: if (scl_fall) begin
						s_cnt <= s_cnt + 3'h1;
						if (s_cnt == 3'h7) begin
							s_sda_oe <= 1'b0;
							s_state  <= S_TACK;
						end else begin
							s_sh     <= {s_sh[6:0], 1'b1};
							s_sda_oe <= ~s_sh[6]; // R8
						end
					end
					S_TACK: begin
						if (scl_rise) begin
							s_sh[0] <= sda_in;
						end
						if (scl_fall) begin
							if (!s_sh[0]) begin
								s_sh     <= s_tx_data; // R11: more wanted
								s_sda_oe <= ~s_tx_data[7];
								s_tx_req <= 1'b1;
								s_state  <= S_TX;
							end else begin
								s_state <= S_IGN; // R11: last byte
							end
						end
					end
					S_IGN: s_sda_oe <= 1'b0; // R17
					default: s_state <= S_IDLE;
				endcase
			end
		end
	end

	// Pin drives; the slave side never pulls the clock
	assign scl_oe = master_mode && m_scl_oe; // R4
	assign sda_oe = master_mode ? m_sda_oe : s_sda_oe; // R4

	// Checks
	sequence start_hold_s;
		(m_state == M_SHOLD && !m_scl_oe && m_sda_oe) [*3];
	endsequence
	logic [7:0] tick_gap; // Operating clocks since the last divider tick
	logic [9:0] hold_cyc; // Operating clocks spent in the start hold

	// Tick spacing counter, restarted wherever the divider restarts
	always_ff @(posedge ref_clk) begin
		if (rst || tick || m_state == M_IDLE) begin
			tick_gap <= 8'h01;
		end else begin
			tick_gap <= tick_gap + 8'h01;
		end
	end

	// Start hold length, cleared while the setup before it runs
	always_ff @(posedge ref_clk) begin
		if (rst || m_state == M_SHIGH) begin
			hold_cyc <= 10'h000;
		end else if (m_state == M_SHOLD) begin
			hold_cyc <= hold_cyc + 10'h001;
		end
	end

	tick_period_a: assert property (@(posedge ref_clk) disable iff (rst) // R1
		tick && m_state != M_IDLE |-> tick_gap == {1'b0, n_eff} + 8'h01)
		else $error("divider tick spacing wrong");
	start_shape_a: assert property (@(posedge ref_clk) disable iff (rst) // R9
		$rose(m_state == M_SHOLD) |-> start_hold_s)
		else $error("start not held with clock high");
	factor_pick_a: assert property (@(posedge ref_clk) disable iff (rst) // R2
		hi_ticks == ((target_khz < `IMSC_SLOW_KHZ) ? 4'd4 : 4'd2))
		else $error("clock factor wrong for rate");
	slave_scl_a: assert property (@(posedge ref_clk) disable iff (rst) // R4
		!master_mode |-> !scl_oe)
		else $error("slave drove the clock");
	start_fall_a: assert property (@(posedge ref_clk) disable iff (rst) // R9
		$rose(m_sda_oe) && master_mode && !m_scl_oe |-> m_state == M_SHOLD)
		else $error("data fell with clock high outside start");
	start_hold_a: assert property (@(posedge ref_clk) disable iff (rst) // R16
		$rose(m_scl_oe) && $past(m_state) == M_SHOLD
		|-> hold_cyc == 10'(`IMSC_START_HOLD) * ({3'h0, n_eff} + 10'h001))
		else $error("start hold too short");
	addr_ack_a: assert property (@(posedge ref_clk) disable iff (rst || master_mode) // R7
		s_state == S_ADDR && scl_fall && s_got8 && !bus_start && !bus_stop
		&& s_sh[7:1] == slave_addr |=> s_sda_oe && s_state == S_AACK)
		else $error("matching address not acknowledged");
	ignore_a: assert property (@(posedge ref_clk) disable iff (rst || master_mode) // R17
		s_state == S_IGN && !bus_start |=> !s_sda_oe)
		else $error("slave drove data for another address");
	otp_once_a: assert property (@(posedge ref_clk) disable iff (rst) // R15
		otp_done |=> $stable(slave_addr))
		else $error("slave address programmed twice");
	read_nack_a: assert property (@(posedge ref_clk) disable iff (rst) // R11
		cmd_valid && cmd_ready && cmd.op == IMSC_OP_READ |=> m_sh[0] == $past(cmd.nack))
		else $error("read acknowledge bit not loaded");
endmodule

// >>> tb/imsc_bus_model.sv
// Far-side bus device: a slave at ADDR, plus master tasks for driving the block as a slave
module imsc_bus_model #(
	parameter logic [6:0] ADDR = 7'h5a, // Address answered when acting as slave
	parameter int         QTR  = 400    // Quarter bit time in ns when acting as master
) (
	// Resolved lines
	input  wire logic scl,
	input  wire logic sda,
	// Open-drain pulls, high pulls the line low
	output logic      scl_oe,
	output logic      sda_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       s_oe    = 1'b0;  // Data pull of the slave side
	logic       m_oe    = 1'b0;  // Data pull of the master side
	logic       again;           // A repeated start cut the transfer short
	logic [7:0] rd_byte = 8'ha5; // Next byte returned on a read
	logic [7:0] rx_q[$];         // Bytes received as slave, address byte included
	logic       mack_q[$];       // Acknowledge bits returned by the master
	int         stops   = 0;     // Stop conditions seen on the wire
	// Both roles share one pin, so their pulls are merged
	assign sda_oe = s_oe | m_oe;
	initial scl_oe = 1'b0;
	// Stop: data rises with clock high
	always @(posedge sda) if (scl === 1'b1) stops++;
	// Shift a byte in on rising clock edges
	task automatic get8(output logic [7:0] v);
		repeat (8) begin
			@(posedge scl);
			v = {v[6:0], sda};
		end
	endtask
	// Hold data low for one bit; released just after the clock falls
	task automatic ack();
		@(negedge scl) #1 s_oe = 1'b1;
		@(negedge scl) #1 s_oe = 1'b0;
	endtask
	// Slave side of one transfer after a start
	task automatic body();
		logic [7:0] a;
		logic [7:0] d;
		get8(a);
		rx_q.push_back(a);
		// Other addresses leave the line released
		if (a[7:1] != ADDR) return;
		ack();
		forever begin
			if (a[0]) begin
				for (int i = 7; i >= 0; i--) begin
					s_oe = ~rd_byte[i];
					@(posedge scl);
					@(negedge scl) #1;
				end
				s_oe = 1'b0;
				rd_byte = ~rd_byte;
				@(posedge scl) mack_q.push_back(sda);
				if (sda) return;
				@(negedge scl) #1;
			end else begin
				get8(d);
				rx_q.push_back(d);
				ack();
			end
		end
	endtask
	// A transfer runs until a stop or a repeated start ends it
	always begin
		@(negedge sda iff scl === 1'b1);
		do begin
			again = 1'b0;
			fork
				body();
				begin
					@(negedge sda iff scl === 1'b1);
					again = 1'b1;
				end
				@(posedge sda iff scl === 1'b1);
			join_any
			disable fork;
			s_oe = 1'b0;
		end while (again);
	end
	// Master bit: data set with clock low, sampled in the high phase
	task automatic m_bit(input logic b, output logic r);
		m_oe = ~b;
		#QTR scl_oe = 1'b0;
		#QTR r = sda;
		#QTR scl_oe = 1'b1;
		#QTR;
	endtask
	// Start or repeated start
	task automatic m_start();
		m_oe = 1'b0;
		#QTR scl_oe = 1'b0;
		#QTR m_oe = 1'b1;
		#QTR scl_oe = 1'b1;
		#QTR;
	endtask
	// Stop ends the frame; clock then stands released
	task automatic m_stop();
		m_oe = 1'b1;
		#QTR scl_oe = 1'b0;
		#QTR m_oe = 1'b0;
		#QTR;
	endtask
	// Byte plus ninth bit; reads send all ones and get the slave's bits back
	task automatic m_byte(input logic [7:0] v, input logic nine,
			output logic [7:0] got, output logic a);
		for (int i = 7; i >= 0; i--) m_bit(v[i], got[i]);
		m_bit(nine, a);
	endtask
endmodule

// >>> tb/tb.sv
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import imsc_pkg::*;
	// Design inputs
	logic        ref_clk     = 1'b0;
	logic        rst         = 1'b1;
	logic        master_mode = 1'b1;
	logic [6:0]  div_n       = 7'h02;
	logic [11:0] target_khz  = 12'h190;
	logic        otp_wr      = 1'b0;
	logic [6:0]  otp_addr    = 7'h23;
	logic        cmd_valid   = 1'b0;
	imsc_cmd_t   cmd         = '0;
	logic [7:0]  s_tx_data   = 8'h6b;
	// Design outputs
	logic        cmd_ready, rsp_valid, s_rx_valid, scl_oe, sda_oe, m_scl, m_sda;
	logic        s_tx_req, s_busy;
	int          n_txreq     = 0;
	imsc_rsp_t   rsp;
	logic [7:0]  s_rx_data;
	logic [7:0]  rx_last;
	int          n_mismatch  = 0;
	int          tests_run   = 0;
	// Pulled-up lines: low while either side pulls
	wire logic   scl         = ~(scl_oe | m_scl);
	wire logic   sda         = ~(sda_oe | m_sda);
	imsc_ctrl dut (.ref_clk, .rst, .master_mode, .div_n, .target_khz, .otp_wr, .otp_addr,
		.cmd_valid, .cmd_ready, .cmd, .rsp_valid, .rsp, .s_rx_valid, .s_rx_data,
		.s_tx_req, .s_tx_data, .s_busy, .scl_in(scl), .scl_oe, .sda_in(sda), .sda_oe);
	imsc_bus_model bus (.scl(scl), .sda(sda), .scl_oe(m_scl), .sda_oe(m_sda));
	always #20 ref_clk = ~ref_clk;
	// Keep the last byte the block received as slave
	always @(posedge ref_clk) if (s_rx_valid === 1'b1) rx_last <= s_rx_data;
	// Count the requests for a byte to send as slave
	always @(posedge ref_clk) if (s_tx_req === 1'b1) n_txreq++;
	task automatic close_out();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// One cycle, inputs move just after the edge; a hang ends the run
	task automatic step(inout int k);
		@(posedge ref_clk) #1;
		k++;
		if (k > 3000) begin
			n_mismatch++;
			close_out();
		end
	endtask
	// Command held until taken, then wait for its answer (a stop has none)
	task automatic do_cmd(input imsc_op_t op, input logic [7:0] ab, input logic nk);
		int k;
		k = 0;
		step(k);
		cmd = {op, ab[7:1], ab[0], ab, nk};
		cmd_valid = 1'b1;
		while (cmd_ready !== 1'b1) step(k);
		step(k);
		cmd_valid = 1'b0;
		if (op != IMSC_OP_STOP)
			while (rsp_valid !== 1'b1) step(k);
	endtask
	// Cycles between the first two clock rises of a transfer
	task automatic meas(output int p);
		int k;
		int n;
		logic l;
		k = 0;
		n = 0;
		l = 1'b1;
		while (n < 2 && k < 2000) begin
			step(k);
			if (scl === 1'b1 && l === 1'b0) begin
				p = (n == 0) ? k : k - p;
				n++;
			end
			l = scl;
		end
		if (n < 2) begin
			n_mismatch++;
			close_out();
		end
	endtask
	task automatic t_mwrite();
		int p;
		fork
			do_cmd(IMSC_OP_ADDR, 8'hb4, 1'b0);
			meas(p);
		join
		chk(16'(p), 16'h0012);
		chk({15'h0, rsp.nack}, 16'h0000);
		do_cmd(IMSC_OP_WRITE, 8'hc3, 1'b0);
		chk({15'h0, rsp.nack}, 16'h0000);
		do_cmd(IMSC_OP_WRITE, 8'h3c, 1'b0);
		chk({bus.rx_q[1], bus.rx_q[2]}, 16'hc33c);
		chk({8'h00, bus.rx_q[0]}, 16'h00b4);
		do_cmd(IMSC_OP_STOP, 8'h00, 1'b0);
	endtask
	// Write then read under one repeated start, slow factor
	task automatic t_mread();
		int p;
		target_khz = 12'h032;
		do_cmd(IMSC_OP_ADDR, 8'hb4, 1'b0);
		chk(16'(bus.stops), 16'h0001);
		// Measured on a byte: a restart's first clock rise is not a bit boundary
		fork
			do_cmd(IMSC_OP_WRITE, 8'h01, 1'b0);
			meas(p);
		join
		chk(16'(p), 16'h0018);
		do_cmd(IMSC_OP_ADDR, 8'hb5, 1'b0);
		chk(16'(bus.stops), 16'h0001);
		chk({15'h0, rsp.nack}, 16'h0000);
		do_cmd(IMSC_OP_READ, 8'h00, 1'b0);
		chk({rsp.data, 7'h00, rsp.nack}, 16'ha500);
		do_cmd(IMSC_OP_READ, 8'h00, 1'b1);
		chk({rsp.data, 7'h00, rsp.nack}, 16'h5a01);
		chk({15'h0, bus.mack_q[0]}, 16'h0000);
		chk({15'h0, bus.mack_q[1]}, 16'h0001);
		do_cmd(IMSC_OP_STOP, 8'h00, 1'b0);
	endtask
	// Absent slaves leave the acknowledge high
	task automatic t_mmiss();
		do_cmd(IMSC_OP_ADDR, 8'h22, 1'b0);
		chk({15'h0, rsp.nack}, 16'h0001);
		do_cmd(IMSC_OP_STOP, 8'h00, 1'b0);
		do_cmd(IMSC_OP_ADDR, 8'hff, 1'b0);
		chk({15'h0, rsp.nack}, 16'h0001);
		do_cmd(IMSC_OP_STOP, 8'h00, 1'b0);
	endtask
	// Slave at the default address, a foreign address, then the programmed one
	task automatic t_slave();
		logic [7:0] g;
		logic a;
		int k;
		k = 0;
		// Let the last stop finish before the role changes
		while (cmd_ready !== 1'b1) step(k);
		master_mode = 1'b0;
		bus.m_start();
		bus.m_byte(8'h80, 1'b1, g, a);
		chk({15'h0, a}, 16'h0000);
		chk({15'h0, s_busy}, 16'h0001);
		bus.m_byte(8'h96, 1'b1, g, a);
		chk({15'h0, a}, 16'h0000);
		bus.m_stop();
		chk({8'h00, rx_last}, 16'h0096);
		chk({15'h0, s_busy}, 16'h0000);
		bus.m_start();
		bus.m_byte(8'h46, 1'b1, g, a);
		chk({15'h0, a}, 16'h0001);
		bus.m_stop();
		@(posedge ref_clk) #1 otp_wr = 1'b1;
		@(posedge ref_clk) #1 otp_wr = 1'b0;
		bus.m_start();
		bus.m_byte(8'h47, 1'b1, g, a);
		chk({15'h0, a}, 16'h0000);
		bus.m_byte(8'hff, 1'b1, g, a);
		chk({8'h00, g}, 16'h006b);
		bus.m_stop();
		chk(16'(n_txreq), 16'h0001);
		otp_addr = 7'h55;
		@(posedge ref_clk) #1 otp_wr = 1'b1;
		@(posedge ref_clk) #1 otp_wr = 1'b0;
		bus.m_start();
		bus.m_byte(8'h46, 1'b1, g, a);
		chk({15'h0, a}, 16'h0000);
		bus.m_stop();
	endtask
	initial begin
		repeat (16) @(posedge ref_clk);
		#1 rst = 1'b0;
		t_mwrite();
		t_mread();
		t_mmiss();
		t_slave();
		close_out();
	end
endmodule
